// ==== hdl/bhp_pkg.sv ====
`default_nettype none

package bhp_pkg;

  // ==========================================================
  // Widths
  // ==========================================================
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned PORT_W = 16;

  // ==========================================================
  // Register offsets
  // ==========================================================
  localparam logic [4:0] GEN_CTRL_ADDR = 5'h00;
  localparam logic [4:0] SVC_ADDR = 5'h01;
  localparam logic [4:0] HIGH_CTRL_ADDR = 5'h06;
  localparam logic [4:0] LOW_CTRL_ADDR = 5'h07;
  localparam logic [4:0] HIGH_DATA_ADDR = 5'h08;
  localparam logic [4:0] LOW_DATA_ADDR = 5'h09;
  localparam logic [4:0] STATUS_ADDR = 5'h0D;

  // ==========================================================
  // Field positions
  // ==========================================================
  localparam int unsigned OUT_HS_EN_BIT = 4;
  localparam int unsigned IN_HS_EN_BIT = 5;
  localparam int unsigned DMA_ON_INPUT_BIT = 0;
  localparam int unsigned PULSED_BIT = 3;
  localparam int unsigned SVC_EN_BIT = 1;
  localparam int unsigned STAT_CTRL_BIT = 0;
  localparam int unsigned ST_OUT_ACK_BIT = 0;
  localparam int unsigned ST_OUT_READY_BIT = 1;
  localparam int unsigned ST_IN_STROBE_BIT = 2;
  localparam int unsigned ST_IN_READY_BIT = 3;

  // ==========================================================
  // Reset values and timing
  // ==========================================================
  localparam logic [7:0] GEN_CTRL_RST = 8'h00;
  localparam logic [7:0] SVC_RST = 8'h00;
  localparam logic [7:0] HIGH_CTRL_RST = 8'h00;
  localparam logic [7:0] LOW_CTRL_RST = 8'h00;
  localparam logic PIN_PREV_RST = 1'b1;
  localparam int unsigned PULSE_CYCLES = 4;

endpackage

`default_nettype wire

// ==== hdl/bhp_hs_if.sv ====
`timescale 1ns/10ps
`default_nettype none

interface bhp_hs_if;
  logic enable;
  logic pulsed;
  logic avail;
  logic edge_seen;
  logic take;
  logic ready;

  modport engine (
    input enable,
    input pulsed,
    input avail,
    input edge_seen,
    output take,
    output ready
  );

  modport user (
    output enable,
    output pulsed,
    output avail,
    output edge_seen,
    input take,
    input ready
  );
endinterface

`default_nettype wire

// ==== hdl/bhp_hs_ready.sv ====
`timescale 1ns/10ps
`default_nettype none

module bhp_hs_ready #(
  parameter int unsigned PULSE_CYCLES = bhp_pkg::PULSE_CYCLES
) (
  input wire logic sys_clk, // System clock
  input wire logic reset,   // Async reset, active high
  bhp_hs_if.engine hs       // Handshake controls and results
);
  localparam int unsigned CW = $clog2(PULSE_CYCLES + 1);

  logic armed_reg;
  logic armed_next;
  logic [CW-1:0] cnt_reg;
  logic take_w;

  // ==========================================================
  // Arming: an edge is only accepted while armed
  // ==========================================================
  assign take_w = hs.enable & armed_reg & hs.avail & hs.edge_seen;

  always_comb
  begin
    armed_next = armed_reg;
    if (!hs.enable)
      armed_next = 1'b0;
    else if (take_w)
      armed_next = 1'b0;
    else if (hs.avail)
      armed_next = 1'b1;
    else
      armed_next = 1'b0;
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      armed_reg <= 1'b0;
    else
      armed_reg <= armed_next;
  end

  // ==========================================================
  // Pulse length counter
  // ==========================================================
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      cnt_reg <= '0;
    else if (armed_next && !armed_reg)
      cnt_reg <= PULSE_CYCLES[CW-1:0];
    else if (!armed_next)
      cnt_reg <= '0;
    else if (cnt_reg != '0)
      cnt_reg <= cnt_reg - 1'b1;
  end

  // Pulsed form stays armed after the pulse, so late edges still count
  assign hs.ready = hs.enable & armed_reg & (!hs.pulsed | (cnt_reg != '0));
  assign hs.take = take_w;
endmodule

`default_nettype wire

// ==== hdl/bhp_port.sv ====
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// [RULE_01] Two bytes form one 16-bit double-buffered path
// [RULE_02] Handshake pairs work only while enabled
// [RULE_03] Direction comes only from acknowledge input
// [RULE_04] Drivers on while acknowledge negated
// [RULE_05] Acknowledge acts on asserted edge only
// [RULE_06] Strobe edge captures pins; reads give final
// [RULE_07] Strobe flag set while unread data held
// [RULE_08] Input ready when room, dropped after strobe
// [RULE_09] Strobes while input not ready ignored; the pulsed form still takes them after the pulse ends
// [RULE_10] Pulsed input ready lasts four cycles max
// [RULE_11] Input ready flag always reads zero
// [RULE_12] Input ready negated while input disabled
// [RULE_13] Acknowledge takes word; next word advances
// [RULE_14] Acknowledge flag: room available or empty
// [RULE_15] Output ready while data, dropped after acknowledge
// [RULE_16] Acknowledges while output not ready ignored; the pulsed form still takes them after the pulse ends
// [RULE_17] Pulsed output ready lasts four cycles max
// [RULE_18] Output ready flag zero; disabled means negated
// [RULE_19] Only low data access advances handshakes
// [RULE_20] Master accesses high byte before low
// [RULE_21] Request follows input or output, not both
// [RULE_22] High write held until low write
// [RULE_23] Control bit 3 picks pulsed form
// [RULE_24] Status control zero: flag while room
// [RULE_25] Service enable gates the request
// [RULE_26] Low data read pops final input latch
module bhp_port (
  input wire logic sys_clk,          // System clock, 100 MHz
  input wire logic reset,            // Async reset, active high
  input wire logic [4:0] reg_addr,   // Register address
  input wire logic [7:0] reg_wdata,  // Register write data
  input wire logic reg_write,        // Write strobe
  input wire logic reg_read,         // Read strobe
  output logic [7:0] reg_rdata,      // Read data, cycle after strobe
  input wire logic [15:0] port_in,   // Port pins, input side
  output logic [15:0] port_out,      // Port pins, output side
  output logic [15:0] port_oe,       // Port pin drive enables
  input wire logic out_ack_in,       // Output acknowledge from peripheral
  output logic out_ready_out,        // Output data ready
  input wire logic in_strobe_in,     // Input strobe from peripheral
  output logic in_ready_out,         // Input latches ready
  output logic dma_request_out       // DMA service request
);

  // ==========================================================
  // Register file
  // ==========================================================
  logic [7:0] gen_ctrl_reg;
  logic [7:0] svc_reg;
  logic [7:0] high_port_control_reg;
  logic [7:0] low_port_control_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic [7:0] status_w;
  logic wr_high;
  logic wr_low;
  logic rd_low;

  assign wr_high = reg_write && (reg_addr == bhp_pkg::HIGH_DATA_ADDR);
  assign wr_low = reg_write && (reg_addr == bhp_pkg::LOW_DATA_ADDR);
  assign rd_low = reg_read && (reg_addr == bhp_pkg::LOW_DATA_ADDR);

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      gen_ctrl_reg <= bhp_pkg::GEN_CTRL_RST;
      svc_reg <= bhp_pkg::SVC_RST;
      high_port_control_reg <= bhp_pkg::HIGH_CTRL_RST;
      low_port_control_reg <= bhp_pkg::LOW_CTRL_RST;
    end
    else if (reg_write)
    begin
      if (reg_addr == bhp_pkg::GEN_CTRL_ADDR)
        gen_ctrl_reg <= reg_wdata;
      else if (reg_addr == bhp_pkg::SVC_ADDR)
        svc_reg <= reg_wdata;
      else if (reg_addr == bhp_pkg::HIGH_CTRL_ADDR)
        high_port_control_reg <= reg_wdata;
      else if (reg_addr == bhp_pkg::LOW_CTRL_ADDR)
        low_port_control_reg <= reg_wdata;
    end
  end

  // ==========================================================
  // Pin edge detection
  // ==========================================================
  logic ack_prev_reg;
  logic strobe_prev_reg;
  logic ack_edge;
  logic strobe_edge;

  // Reset high so a pin already asserted at release is no edge
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      ack_prev_reg <= bhp_pkg::PIN_PREV_RST;
      strobe_prev_reg <= bhp_pkg::PIN_PREV_RST;
    end
    else
    begin
      ack_prev_reg <= out_ack_in;
      strobe_prev_reg <= in_strobe_in;
    end
  end

  assign ack_edge = out_ack_in & ~ack_prev_reg; // [RULE_05]
  assign strobe_edge = in_strobe_in & ~strobe_prev_reg;

  // ==========================================================
  // Handshake engines
  // ==========================================================
  bhp_hs_if in_hs ();
  bhp_hs_if out_hs ();

  logic fin_in_v_reg;
  logic init_in_v_reg;
  logic fin_out_v_reg;
  logic init_out_v_reg;

  assign in_hs.enable = gen_ctrl_reg[bhp_pkg::IN_HS_EN_BIT]; // [RULE_02] [RULE_12]
  assign in_hs.pulsed = low_port_control_reg[bhp_pkg::PULSED_BIT]; // [RULE_23] [RULE_10]
  assign in_hs.avail = ~(fin_in_v_reg & init_in_v_reg); // [RULE_08]
  assign in_hs.edge_seen = strobe_edge; // [RULE_09]

  assign out_hs.enable = gen_ctrl_reg[bhp_pkg::OUT_HS_EN_BIT]; // [RULE_02] [RULE_18]
  assign out_hs.pulsed = high_port_control_reg[bhp_pkg::PULSED_BIT]; // [RULE_23] [RULE_17]
  assign out_hs.avail = fin_out_v_reg; // [RULE_15]
  assign out_hs.edge_seen = ack_edge; // [RULE_16]

  bhp_hs_ready #(
    .PULSE_CYCLES(bhp_pkg::PULSE_CYCLES)
  ) u_in_hs (
    .sys_clk(sys_clk),
    .reset(reset),
    .hs(in_hs)
  );

  bhp_hs_ready #(
    .PULSE_CYCLES(bhp_pkg::PULSE_CYCLES)
  ) u_out_hs (
    .sys_clk(sys_clk),
    .reset(reset),
    .hs(out_hs)
  );

  assign in_ready_out = in_hs.ready;
  assign out_ready_out = out_hs.ready;

  // ==========================================================
  // Input double buffer
  // ==========================================================
  logic [15:0] fin_in_reg;
  logic [15:0] init_in_reg;
  logic pop_in;

  assign pop_in = rd_low & fin_in_v_reg; // [RULE_19] [RULE_26]

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      fin_in_reg <= 16'h0000;
      init_in_reg <= 16'h0000;
      fin_in_v_reg <= 1'b0;
      init_in_v_reg <= 1'b0;
    end
    else if (pop_in && in_hs.take)
    begin
      if (init_in_v_reg)
      begin
        fin_in_reg <= init_in_reg;
        init_in_reg <= port_in;
      end
      else
        fin_in_reg <= port_in; // [RULE_06]
    end
    else if (pop_in)
    begin
      if (init_in_v_reg)
      begin
        fin_in_reg <= init_in_reg; // [RULE_26]
        init_in_v_reg <= 1'b0;
      end
      else
        fin_in_v_reg <= 1'b0;
    end
    else if (in_hs.take)
    begin
      if (!fin_in_v_reg)
      begin
        fin_in_reg <= port_in; // [RULE_06] [RULE_01]
        fin_in_v_reg <= 1'b1;
      end
      else
      begin
        init_in_reg <= port_in; // [RULE_06]
        init_in_v_reg <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Output double buffer
  // ==========================================================
  logic [7:0] temp_high_reg;
  logic [15:0] fin_out_reg;
  logic [15:0] init_out_reg;
  logic [15:0] word_w;
  logic push_out;

  // Master must write the high byte first; the low write completes the word
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      temp_high_reg <= 8'h00;
    else if (wr_high)
      temp_high_reg <= reg_wdata; // [RULE_22] [RULE_20]
  end

  assign word_w = {temp_high_reg, reg_wdata}; // [RULE_22]
  // Write into a full path is dropped, nothing to stall the master with
  assign push_out = wr_low & ~(fin_out_v_reg & init_out_v_reg); // [RULE_19]

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      fin_out_reg <= 16'h0000;
      init_out_reg <= 16'h0000;
      fin_out_v_reg <= 1'b0;
      init_out_v_reg <= 1'b0;
    end
    else if (push_out && out_hs.take)
    begin
      if (init_out_v_reg)
      begin
        fin_out_reg <= init_out_reg;
        init_out_reg <= word_w;
      end
      else
        fin_out_reg <= word_w;
    end
    else if (out_hs.take)
    begin
      if (init_out_v_reg)
      begin
        fin_out_reg <= init_out_reg; // [RULE_13]
        init_out_v_reg <= 1'b0;
      end
      else
        fin_out_v_reg <= 1'b0;
    end
    else if (push_out)
    begin
      if (!fin_out_v_reg)
      begin
        fin_out_reg <= word_w; // [RULE_13] [RULE_01]
        fin_out_v_reg <= 1'b1;
      end
      else
      begin
        init_out_reg <= word_w;
        init_out_v_reg <= 1'b1;
      end
    end
  end

  // Submode and direction fields do not exist here; acknowledge level alone decides
  assign port_out = fin_out_reg;
  assign port_oe = {16{~out_ack_in}}; // [RULE_03] [RULE_04]

  // ==========================================================
  // Status, request and read data
  // ==========================================================
  logic out_ack_status;
  logic in_strobe_status;
  logic dma_reg;

  always_comb
  begin
    if (high_port_control_reg[bhp_pkg::STAT_CTRL_BIT])
      out_ack_status = ~fin_out_v_reg & ~init_out_v_reg; // [RULE_14]
    else
      out_ack_status = ~(fin_out_v_reg & init_out_v_reg); // [RULE_24]
  end

  assign in_strobe_status = fin_in_v_reg | init_in_v_reg; // [RULE_07]

  always_comb
  begin
    status_w = 8'h00;
    status_w[bhp_pkg::ST_OUT_ACK_BIT] = out_ack_status;
    status_w[bhp_pkg::ST_OUT_READY_BIT] = 1'b0; // [RULE_18]
    status_w[bhp_pkg::ST_IN_STROBE_BIT] = in_strobe_status;
    status_w[bhp_pkg::ST_IN_READY_BIT] = 1'b0; // [RULE_11]
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      dma_reg <= 1'b0;
    else if (svc_reg[bhp_pkg::DMA_ON_INPUT_BIT])
      dma_reg <= in_strobe_status & low_port_control_reg[bhp_pkg::SVC_EN_BIT]; // [RULE_21] [RULE_25]
    else
      dma_reg <= out_ack_status & high_port_control_reg[bhp_pkg::SVC_EN_BIT]; // [RULE_21]
  end

  assign dma_request_out = dma_reg;

  always_comb
  begin
    rdata_next = 8'h00;
    if (reg_addr == bhp_pkg::GEN_CTRL_ADDR)
      rdata_next = gen_ctrl_reg;
    else if (reg_addr == bhp_pkg::SVC_ADDR)
      rdata_next = svc_reg;
    else if (reg_addr == bhp_pkg::HIGH_CTRL_ADDR)
      rdata_next = high_port_control_reg;
    else if (reg_addr == bhp_pkg::LOW_CTRL_ADDR)
      rdata_next = low_port_control_reg;
    else if (reg_addr == bhp_pkg::HIGH_DATA_ADDR)
      rdata_next = fin_in_reg[15:8];
    else if (reg_addr == bhp_pkg::LOW_DATA_ADDR)
      rdata_next = fin_in_reg[7:0]; // [RULE_06]
    else if (reg_addr == bhp_pkg::STATUS_ADDR)
      rdata_next = status_w;
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      rdata_reg <= 8'h00;
    else if (reg_read)
      rdata_reg <= rdata_next;
    else
      rdata_reg <= 8'h00;
  end

  assign reg_rdata = rdata_reg;

  // ==========================================================
  // Assertions
  // ==========================================================
  a_drivers_follow_ack: assert property (@(posedge sys_clk) disable iff (reset) // [RULE_04]
    port_oe == {16{~out_ack_in}})
    else $error("drivers do not follow acknowledge level");

  a_in_ready_disabled: assert property (@(posedge sys_clk) disable iff (reset) // [RULE_12]
    !gen_ctrl_reg[bhp_pkg::IN_HS_EN_BIT] |-> !in_ready_out)
    else $error("input ready high while disabled");

  a_out_ready_disabled: assert property (@(posedge sys_clk) disable iff (reset) // [RULE_18]
    !gen_ctrl_reg[bhp_pkg::OUT_HS_EN_BIT] |-> !out_ready_out)
    else $error("output ready high while disabled");

  a_in_pulse_max: assert property (@(posedge sys_clk) disable iff (reset) // [RULE_10]
    (in_hs.pulsed && in_ready_out)[*4] |=> !in_ready_out)
    else $error("input ready pulse longer than four cycles");

  a_out_pulse_max: assert property (@(posedge sys_clk) disable iff (reset) // [RULE_17]
    (out_hs.pulsed && out_ready_out)[*4] |=> !out_ready_out)
    else $error("output ready pulse longer than four cycles");

  a_take_drops_ready: assert property (@(posedge sys_clk) disable iff (reset) // [RULE_08]
    in_hs.take |=> !in_ready_out)
    else $error("input ready not dropped after strobe");

  a_strobe_ignored: assert property (@(posedge sys_clk) disable iff (reset) // [RULE_09]
    (strobe_edge && !in_ready_out && !in_hs.pulsed && !pop_in) |=> $stable({fin_in_v_reg, init_in_v_reg}))
    else $error("strobe taken while not ready");

  a_status_ready_zero: assert property (@(posedge sys_clk) disable iff (reset) // [RULE_11]
    (reg_read && reg_addr == bhp_pkg::STATUS_ADDR) |=> (reg_rdata[3] == 1'b0 && reg_rdata[1] == 1'b0))
    else $error("ready status bits not zero");

  a_pop_final: assert property (@(posedge sys_clk) disable iff (reset) // [RULE_26]
    (pop_in && !init_in_v_reg && !in_hs.take) |=> (!fin_in_v_reg && !in_strobe_status))
    else $error("low read did not empty final input latch");

  a_high_write_inert: assert property (@(posedge sys_clk) disable iff (reset) // [RULE_19]
    (wr_high && !out_hs.take) |=> $stable({fin_out_v_reg, init_out_v_reg}))
    else $error("high write moved the output path");

  a_word_pairing: assert property (@(posedge sys_clk) disable iff (reset) // [RULE_22]
    (wr_low && !fin_out_v_reg) |=> (port_out == {$past(temp_high_reg), $past(reg_wdata)}))
    else $error("output word not paired from high and low writes");

endmodule

`default_nettype wire

// ==== testbench/bhp_periph_model.sv ====
`timescale 1ns/10ps
`default_nettype none

// ========
// Peripheral on the far side of the port
// ========
module bhp_periph_model (
  input wire logic sys_clk,          // Clock
  input wire logic reset,            // Reset, active high
  input wire logic out_ready_out,    // Port has a word
  input wire logic in_ready_out,     // Port has room
  input wire logic [15:0] port_out,  // Port output latch
  input wire logic [15:0] port_oe,   // Port drive enables
  output logic [15:0] port_in,       // Resolved pin levels
  output logic out_ack_in,           // Acknowledge
  output logic in_strobe_in,         // Input strobe
  input wire logic ack_en,           // Take words
  input wire logic [3:0] ack_wait,   // Extra low cycles of acknowledge
  input wire logic send_go,          // Send one word
  input wire logic send_force,       // Strobe even when not ready
  input wire logic [15:0] send_word, // Word to send
  output logic busy,                 // Transfer under way
  output logic got_valid,            // Word taken
  output logic [15:0] got_word       // Taken word
);
  logic [15:0] drive_reg;
  logic [1:0] ack_st_reg;
  logic [3:0] ack_cnt_reg;
  logic [1:0] snd_st_reg;

  // Pins follow the port while it drives, else this model
  assign port_in = (port_oe & port_out) | (~port_oe & drive_reg);
  assign busy = (ack_st_reg != 2'h0) || (snd_st_reg != 2'h0);

  // ========
  // Output side
  // ========
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      out_ack_in <= 1'b1;
      ack_st_reg <= 2'h0;
      ack_cnt_reg <= 4'h0;
      got_valid <= 1'b0;
      got_word <= 16'h0000;
    end
    else
    begin
      got_valid <= 1'b0;
      case (ack_st_reg)
        2'h0:
          if (ack_en && out_ready_out)
          begin
            out_ack_in <= 1'b0;
            ack_cnt_reg <= ack_wait;
            ack_st_reg <= 2'h1;
          end
        2'h1:
          if (ack_cnt_reg == 4'h0)
          begin
            out_ack_in <= 1'b1;
            got_valid <= 1'b1;
            got_word <= port_out;
            ack_st_reg <= 2'h2;
          end
          else
            ack_cnt_reg <= ack_cnt_reg - 4'h1;
        default:
          ack_st_reg <= ack_st_reg + 2'h1;
      endcase
    end
  end

  // ========
  // Input side
  // ========
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      in_strobe_in <= 1'b0;
      snd_st_reg <= 2'h0;
      drive_reg <= 16'h0000;
    end
    else
      case (snd_st_reg)
        2'h0:
          if (send_go)
          begin
            drive_reg <= send_word;
            snd_st_reg <= 2'h1;
          end
          else
            drive_reg <= ~drive_reg; // Idle lines toggle each cycle, so no stale word is held steady
        2'h1:
          if (send_force || in_ready_out)
          begin
            in_strobe_in <= 1'b1;
            snd_st_reg <= 2'h2;
          end
        default:
        begin
          in_strobe_in <= 1'b0;
          snd_st_reg <= 2'h0;
        end
      endcase
  end
endmodule

`default_nettype wire

// ==== testbench/bhp_port_tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none

module bhp_port_tb_top;
  localparam logic [4:0] GC = bhp_pkg::GEN_CTRL_ADDR;
  localparam logic [4:0] SV = bhp_pkg::SVC_ADDR;
  localparam logic [4:0] HC = bhp_pkg::HIGH_CTRL_ADDR;
  localparam logic [4:0] LC = bhp_pkg::LOW_CTRL_ADDR;
  localparam logic [4:0] HD = bhp_pkg::HIGH_DATA_ADDR;
  localparam logic [4:0] LD = bhp_pkg::LOW_DATA_ADDR;
  localparam logic [4:0] ST = bhp_pkg::STATUS_ADDR;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic [4:0] reg_addr = 5'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [7:0] reg_rdata;
  logic [15:0] port_in;
  logic [15:0] port_out;
  logic [15:0] port_oe;
  logic out_ack_in;
  logic out_ready_out;
  logic in_strobe_in;
  logic in_ready_out;
  logic dma_request_out;
  logic ack_en = 1'b0;
  logic [3:0] ack_wait = 4'h0;
  logic send_go = 1'b0;
  logic send_force = 1'b0;
  logic [15:0] send_word = 16'h0000;
  logic busy;
  logic got_valid;
  logic [15:0] got_word;
  logic rd_flag = 1'b0;
  logic [7:0] exp_rd[$];
  logic [15:0] exp_words[$];
  logic [31:0] rnd = 32'h7c49_8202;
  logic [15:0] w[4];
  int num_errors = 0;
  int checked = 0;
  int in_len = 0;
  int in_run = 0;
  int out_len = 0;
  int out_run = 0;

  always #5 sys_clk = ~sys_clk;

  bhp_port bhp_port_inst (.sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .port_in(port_in),
    .port_out(port_out), .port_oe(port_oe), .out_ack_in(out_ack_in), .out_ready_out(out_ready_out),
    .in_strobe_in(in_strobe_in), .in_ready_out(in_ready_out), .dma_request_out(dma_request_out));

  bhp_periph_model bhp_periph_model_inst (.sys_clk(sys_clk), .reset(reset), .out_ready_out(out_ready_out),
    .in_ready_out(in_ready_out), .port_out(port_out), .port_oe(port_oe), .port_in(port_in),
    .out_ack_in(out_ack_in), .in_strobe_in(in_strobe_in), .ack_en(ack_en), .ack_wait(ack_wait),
    .send_go(send_go), .send_force(send_force), .send_word(send_word), .busy(busy),
    .got_valid(got_valid), .got_word(got_word));

  // ========
  // Shared tasks
  // ========
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic chk1(input string what, input logic seen, input logic exp);
    chk(what, {15'h0000, seen}, {15'h0000, exp});
  endtask

  task automatic conclude();
    if (num_errors == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic rand16(output logic [15:0] v);
    rnd = lfsr(rnd);
    v = rnd[15:0];
  endtask

  task automatic do_reset();
    reset <= 1'b1;
    in_run = 0;
    out_run = 0;
    in_len = 0;
    out_len = 0;
    repeat (4) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
  endtask

  // One idle cycle after each strobe keeps every access one cycle long
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge sys_clk);
    reg_write <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    exp_rd.push_back(e);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge sys_clk);
    reg_read <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic put_word(input logic [15:0] v);
    wr(HD, v[15:8]);
    wr(LD, v[7:0]);
  endtask

  task automatic settle();
    int n;
    n = 0;
    do
    begin
      @(negedge sys_clk);
      n++;
    end
    while ((busy || exp_words.size() != 0) && n < 200);
    chk1("partner idle", busy, 1'b0);
    @(posedge sys_clk);
  endtask

  task automatic send(input logic [15:0] v, input logic f);
    send_word <= v;
    send_force <= f;
    send_go <= 1'b1;
    @(posedge sys_clk);
    send_go <= 1'b0;
    settle();
  endtask

  // ========
  // Output monitor
  // ========
  always @(posedge sys_clk)
    rd_flag <= reg_read;

  always @(negedge sys_clk)
  begin
    if (!reset)
    begin
      chk("port_oe", port_oe, {16{~out_ack_in}});
      if (rd_flag)
        chk("reg_rdata", {8'h00, reg_rdata}, {8'h00, exp_rd.pop_front()});
      if (got_valid === 1'b1)
        chk("taken word", got_word, exp_words.pop_front());
      if (in_ready_out === 1'b1)
        in_len++;
      else
      begin
        if (in_len != 0)
          in_run = in_len;
        in_len = 0;
      end
      if (out_ready_out === 1'b1)
        out_len++;
      else
      begin
        if (out_len != 0)
          out_run = out_len;
        out_len = 0;
      end
    end
  end

  initial
  begin
    #200000;
    num_errors++;
    conclude();
  end

  // ========
  // Main sequence
  // ========
  initial
  begin
    do_reset();
    rd(GC, bhp_pkg::GEN_CTRL_RST);
    rd(SV, bhp_pkg::SVC_RST);
    rd(HC, bhp_pkg::HIGH_CTRL_RST);
    rd(LC, bhp_pkg::LOW_CTRL_RST);
    wr(ST, 8'hFF);
    rd(ST, 8'h01);
    rd(5'h1F, 8'h00);
    chk1("in ready off", in_ready_out, 1'b0);
    chk1("out ready off", out_ready_out, 1'b0);
    // Output path, interlocked
    wr(SV, 8'h00);
    wr(HC, 8'h02);
    wr(GC, 8'h30);
    @(negedge sys_clk);
    chk1("dma out empty", dma_request_out, 1'b1);
    @(posedge sys_clk);
    for (int i = 0; i < 3; i++)
    begin
      rand16(w[i]);
      put_word(w[i]);
    end
    exp_words.push_back(w[0]);
    exp_words.push_back(w[1]);
    rand16(w[3]);
    wr(HD, w[3][15:8]);
    rd(ST, 8'h00);
    @(negedge sys_clk);
    chk1("out ready full", out_ready_out, 1'b1);
    chk1("dma out full", dma_request_out, 1'b0);
    @(posedge sys_clk);
    ack_en <= 1'b1;
    ack_wait <= 4'h5;
    settle();
    rd(ST, 8'h01);
    exp_words.push_back(w[3]);
    ack_wait <= 4'h0;
    wr(LD, w[3][7:0]);
    settle();
    // Status control set: flag only when both latches empty
    ack_en <= 1'b0;
    wr(HC, 8'h03);
    rand16(w[0]);
    put_word(w[0]);
    exp_words.push_back(w[0]);
    rd(ST, 8'h00);
    wr(HC, 8'h02);
    rd(ST, 8'h01);
    ack_en <= 1'b1;
    settle();
    // Pulsed output, peripheral silent
    ack_en <= 1'b0;
    wr(HC, 8'h08);
    rand16(w[0]);
    put_word(w[0]);
    repeat (12) @(posedge sys_clk);
    chk("out pulse", 16'(out_run), 16'(bhp_pkg::PULSE_CYCLES));
    chk1("dma off", dma_request_out, 1'b0);
    // Input path, interlocked
    do_reset();
    wr(SV, 8'h01);
    wr(LC, 8'h02);
    wr(HC, 8'h02);
    wr(GC, 8'h20);
    for (int i = 0; i < 3; i++)
      rand16(w[i]);
    send(w[0], 1'b0);
    send(w[1], 1'b0);
    send(w[2], 1'b1);
    @(negedge sys_clk);
    chk1("in ready full", in_ready_out, 1'b0);
    chk1("dma in held", dma_request_out, 1'b1);
    @(posedge sys_clk);
    rd(ST, 8'h05);
    rd(HD, w[0][15:8]);
    rd(HD, w[0][15:8]);
    rd(LD, w[0][7:0]);
    rd(HD, w[1][15:8]);
    rd(LD, w[1][7:0]);
    rd(ST, 8'h01);
    @(negedge sys_clk);
    chk1("dma in empty", dma_request_out, 1'b0);
    chk1("in ready room", in_ready_out, 1'b1);
    @(posedge sys_clk);
    // Pulsed input
    do_reset();
    wr(LC, 8'h08);
    wr(GC, 8'h20);
    repeat (12) @(posedge sys_clk);
    chk("in pulse", 16'(in_run), 16'(bhp_pkg::PULSE_CYCLES));
    rand16(w[0]);
    send(w[0], 1'b1);
    rd(ST, 8'h05);
    rd(LD, w[0][7:0]);
    chk("queues", 16'(exp_rd.size() + exp_words.size()), 16'h0000);
    conclude();
  end
endmodule

`default_nettype wire
